// file: rtl/tss_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the start-up sequencer
// Assumes: 100 MHz ref_clk
// Notes: Definitions only
`ifndef TSS_MAP_SVH
`define TSS_MAP_SVH

// Register offsets (byte addresses, one word each)
`define TSS_ADDR_CTRL 8'h00
`define TSS_ADDR_STATUS 8'h04
`define TSS_ADDR_MASK 8'h08
`define TSS_ADDR_STATE 8'h0C

// Control fields and reset value
`define TSS_CTRL_RUN_BIT 0
`define TSS_CTRL_RESET 32'h0000_0001

// Status / mask bit positions
`define TSS_ST_FAULT 0
`define TSS_ST_DONE 1
`define TSS_ST_OTEMP 2
`define TSS_ST_PEAK 3
`define TSS_ST_WIDTH 4
`define TSS_MASK_RESET 4'h0

// State register fields
`define TSS_STATE_LSB 0
`define TSS_CYCLE_LSB 4
`define TSS_CAUSE_LSB 8

// Sequence points (one cycle = one rise and one fall of the delay capacitor)
`define TSS_CYC_INIT_LAST 3'h2
`define TSS_CYC_GATE 3'h2
`define TSS_CYC_BOOST 3'h3
`define TSS_CYC_ROWNEG 3'h4
`define TSS_CYC_DELAY 3'h5
`define TSS_CYC_ROWPOS 3'h6
`define TSS_CYC_LAST 3'h6

// Analog thresholds, for reference by the comparators outside
`define TSS_SUPPLY_MV 2500
`define TSS_REF_MV 1200
`define TSS_UV_PCT 25
`define TSS_UV_MV (`TSS_REF_MV * (100 - `TSS_UV_PCT) / 100)
`define TSS_OTEMP_C 130

// Fast part of each rising ramp
`define TSS_CLK_NS 10
`define TSS_FAST_RAMP_NS 20000
`define TSS_FAST_RAMP_CYC ((`TSS_FAST_RAMP_NS + `TSS_CLK_NS - 1) / `TSS_CLK_NS)

`endif

// file: rtl/tss_pkg.sv
// Purpose: Types of the start-up sequencer
// Assumes: Nothing
// Notes: Numbers live in tss_map.svh
package tss_pkg;

	typedef enum logic [2:0]
	{
		TSS_OFF = 3'b000,
		TSS_UP = 3'b001,
		TSS_DOWN = 3'b010,
		TSS_DONE = 3'b011,
		TSS_LATCH = 3'b100
	} tss_state_type;

	// Comparator and detector levels from the analog side, all active high
	typedef struct packed
	{
		logic enable;
		logic supplyOk;
		logic capHigh;
		logic capLow;
		logic capFault;
		logic refOk;
		logic overTemp;
		logic boostDelayedOk;
		logic protGateOk;
		logic rowNegOk;
		logic delayGateOk;
		logic rowPosOk;
		logic logicOk;
	} tss_sense_type;

	// Bus request from the register master
	typedef struct packed
	{
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} tss_bus_type;

endpackage

// file: rtl/tss_sequencer.sv
// Purpose: Start-up sequencer for a four-output display power controller
// Assumes: One 100 MHz clock; analog comparators arrive asynchronously
// Notes: VARIANT_A selects the variant with early reference and logic supply
//
// Operation
// - Enable low keeps the sequencer powered down, all outputs inactive but the second variant's reference.
// - Enable high and supply above 2.5V start charging, fast then slow.
// - Supply good but enable low: ramping waits for enable.
// - Fault-free power-up gives exactly six capacitor peaks, ramping until done.
// - First two cycles set up protection and check capacitor and reference.
// - Initialization fault turns everything off; second variant keeps reference on.
// - Any fault latches off until enable toggles, supply is recycled or the run bit is cleared.
// - Second ramp checks reference status and over-temperature.
// - At second peak the protection gate goes low, enabling input switch.
// - Any fault turns the input protection switch off.
// - Base variant soft-starts boost and logic supply at third ramp.
// - Second variant enables reference once supply passes 2.5V, and logic supply once enable is high as well.
// - Negative row supply turns on as the fourth ramp begins.
// - At fifth peak the delayed-output gate goes low.
// - Positive row supply turns on at start of sixth ramp.
// - End of sixth ramp checks delayed boost, gates and row supplies.
// - Over-temperature at any time shuts the device down.
// - Each regulator has an under-voltage detector, positive ones at 0.9V.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`include "tss_map.svh"
`timescale 1ns/10ps
`default_nettype none

module tss_sequencer
#(
	parameter bit VARIANT_A = 1'b0,
	parameter int FAST_CYC = `TSS_FAST_RAMP_CYC
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Analog comparators and pins
	input wire tss_pkg::tss_sense_type senseIn,
	// Register port
	input wire tss_pkg::tss_bus_type busIn,
	output logic [31:0] rdata,
	// Delay capacitor drive
	output logic delayCapCharge,
	output logic delayCapFast,
	output logic delayCapDischarge,
	// Supply controls
	output logic refEnable,
	output logic boostEnable,
	output logic logicEnable,
	output logic rowNegEnable,
	output logic rowPosEnable,
	output logic protectionGateOut_n,
	output logic delayedOutputGate_n,
	// Status
	output logic faultLatched,
	output logic irq
);
	import tss_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	tss_sense_type sense1_r;
	tss_sense_type sense_r;
	logic capHighPrev_r;
	logic capLowPrev_r;

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			sense1_r <= '0;
			sense_r <= '0;
		end
		else
		begin
			sense1_r <= senseIn;
			sense_r <= sense1_r;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			capHighPrev_r <= 1'b0;
			capLowPrev_r <= 1'b0;
		end
		else
		begin
			capHighPrev_r <= sense_r.capHigh;
			capLowPrev_r <= sense_r.capLow;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [31:0] ctrl_r;
	logic [`TSS_ST_WIDTH-1:0] status_r;
	logic [`TSS_ST_WIDTH-1:0] mask_r;
	logic [`TSS_ST_WIDTH-1:0] statusSet;
	logic [`TSS_ST_WIDTH-1:0] statusClr;
	logic [7:0] cause_r;

	tss_state_type state_r;
	tss_state_type state_nxt;
	logic [2:0] cycle_r;
	logic [2:0] cycle_nxt;
	logic [$clog2(FAST_CYC+1)-1:0] fastCnt_r;

	logic runOk;
	logic peakEvt;
	logic troughEvt;
	logic active;
	logic initFault;
	logic endFault;
	logic runFault;
	logic faultNow;
	logic endOfSeq;
	logic [7:0] causeNow;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			ctrl_r <= `TSS_CTRL_RESET;
			mask_r <= `TSS_MASK_RESET;
		end
		else if (busIn.wr)
		begin
			if (hit(busIn.addr, `TSS_ADDR_CTRL))
				ctrl_r <= {31'h0000_0000, busIn.wdata[`TSS_CTRL_RUN_BIT]};
			else if (hit(busIn.addr, `TSS_ADDR_MASK))
				mask_r <= busIn.wdata[`TSS_ST_WIDTH-1:0];
		end
	end

	always_comb
	begin
		statusClr = '0;
		if (busIn.wr && hit(busIn.addr, `TSS_ADDR_STATUS))
			statusClr = busIn.wdata[`TSS_ST_WIDTH-1:0];
		statusSet = '0;
		statusSet[`TSS_ST_FAULT] = active && faultNow;
		statusSet[`TSS_ST_DONE] = (state_r == TSS_DOWN) && troughEvt && endOfSeq && !faultNow;
		statusSet[`TSS_ST_OTEMP] = active && sense_r.overTemp;
		statusSet[`TSS_ST_PEAK] = (state_r == TSS_UP) && peakEvt;
	end

	// Set wins over a simultaneous clear
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			status_r <= '0;
		else
			status_r <= (status_r & ~statusClr) | statusSet;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			irq <= 1'b0;
		else
			irq <= |(((status_r & ~statusClr) | statusSet) & mask_r);
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			rdata <= 32'h0000_0000;
		else if (!busIn.rd)
			rdata <= 32'h0000_0000;
		else if (hit(busIn.addr, `TSS_ADDR_CTRL))
			rdata <= ctrl_r;
		else if (hit(busIn.addr, `TSS_ADDR_STATUS))
			rdata <= {28'h000_0000, status_r};
		else if (hit(busIn.addr, `TSS_ADDR_MASK))
			rdata <= {28'h000_0000, mask_r};
		else if (hit(busIn.addr, `TSS_ADDR_STATE))
			rdata <= {16'h0000, cause_r, 1'b0, cycle_r, 1'b0, state_r};
		else
			rdata <= 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequence control

	assign runOk = sense_r.enable && sense_r.supplyOk && ctrl_r[`TSS_CTRL_RUN_BIT];
	// Threshold crossings advance the sequence
	assign peakEvt = sense_r.capHigh && !capHighPrev_r;
	assign troughEvt = sense_r.capLow && !capLowPrev_r;
	assign active = (state_r == TSS_UP) || (state_r == TSS_DOWN) || (state_r == TSS_DONE);
	assign endOfSeq = (cycle_r == `TSS_CYC_LAST);

	// Capacitor and reference checked through the first two cycles
	assign initFault = (state_r != TSS_DONE) && (cycle_r <= `TSS_CYC_INIT_LAST)
		&& (sense_r.capFault || !sense_r.refOk);
	// Final check of every sequenced output
	assign endFault = (state_r == TSS_DOWN) && troughEvt && endOfSeq
		&& !(sense_r.boostDelayedOk && sense_r.protGateOk && sense_r.rowNegOk
		&& sense_r.delayGateOk && sense_r.rowPosOk && sense_r.logicOk);
	// Once up, losing any supply is a fault too
	assign runFault = (state_r == TSS_DONE)
		&& !(sense_r.boostDelayedOk && sense_r.rowNegOk && sense_r.rowPosOk && sense_r.logicOk);
	assign faultNow = sense_r.overTemp || initFault || endFault || runFault;
	assign causeNow = {1'b0, sense_r.overTemp, initFault, endFault, runFault, cycle_r};

	always_comb
	begin
		state_nxt = state_r;
		cycle_nxt = cycle_r;
		case (state_r)
			TSS_OFF:
			begin
				// Supply good with enable low simply waits here
				if (runOk)
				begin
					state_nxt = TSS_UP;
					cycle_nxt = 3'h1;
				end
			end
			TSS_UP:
			begin
				if (peakEvt)
					state_nxt = TSS_DOWN;
			end
			TSS_DOWN:
			begin
				if (troughEvt && endOfSeq)
					state_nxt = TSS_DONE;
				else if (troughEvt)
				begin
					state_nxt = TSS_UP;
					cycle_nxt = cycle_r + 3'h1;
				end
			end
			TSS_DONE:
				state_nxt = TSS_DONE;
			TSS_LATCH:
				state_nxt = TSS_LATCH;
			default:
				state_nxt = TSS_OFF;
		endcase
		if (active && faultNow)
			state_nxt = TSS_LATCH;
		if (!runOk)
		begin
			// Enable toggle, supply loss or a cleared run bit are the only ways out of the latch
			state_nxt = TSS_OFF;
			cycle_nxt = 3'h0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			state_r <= TSS_OFF;
			cycle_r <= 3'h0;
		end
		else
		begin
			state_r <= state_nxt;
			cycle_r <= cycle_nxt;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			cause_r <= 8'h00;
		else if (state_r == TSS_OFF && runOk)
			cause_r <= 8'h00;
		else if (active && faultNow)
			cause_r <= causeNow;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Delay capacitor drive

	// Fast current first, slow current for the rest of each rise
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			delayCapCharge <= 1'b0;
			delayCapDischarge <= 1'b0;
			delayCapFast <= 1'b0;
			fastCnt_r <= '0;
		end
		else
		begin
			delayCapCharge <= (state_nxt == TSS_UP);
			delayCapDischarge <= (state_nxt == TSS_DOWN);
			if (state_nxt == TSS_UP && state_r != TSS_UP)
			begin
				fastCnt_r <= '0;
				delayCapFast <= 1'b1;
			end
			else if (state_nxt == TSS_UP && state_r == TSS_UP && delayCapFast)
			begin
				fastCnt_r <= fastCnt_r + 1'b1;
				delayCapFast <= (fastCnt_r < ($clog2(FAST_CYC+1))'(FAST_CYC - 1));
			end
			else
				delayCapFast <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Supply sequencing

	logic goOff;
	logic stepUp;

	// Fault or power-down drops every output in the same edge, bar the second variant's reference and, on power-down by the run bit alone, its logic supply
	assign goOff = (state_nxt == TSS_OFF) || (state_nxt == TSS_LATCH);
	assign stepUp = (state_r == TSS_DOWN) && (state_nxt == TSS_UP);

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			boostEnable <= 1'b0;
			logicEnable <= 1'b0;
			rowNegEnable <= 1'b0;
			rowPosEnable <= 1'b0;
			protectionGateOut_n <= 1'b1;
			delayedOutputGate_n <= 1'b1;
			faultLatched <= 1'b0;
			refEnable <= 1'b0;
		end
		else
		begin
			faultLatched <= (state_nxt == TSS_LATCH);
			// Reference runs from supply alone in the second variant
			refEnable <= VARIANT_A ? sense_r.supplyOk : !goOff;
			if (goOff)
			begin
				boostEnable <= 1'b0;
				rowNegEnable <= 1'b0;
				rowPosEnable <= 1'b0;
				protectionGateOut_n <= 1'b1;
				delayedOutputGate_n <= 1'b1;
				logicEnable <= VARIANT_A && (state_nxt == TSS_OFF) && sense_r.supplyOk
					&& sense_r.enable;
			end
			else
			begin
				if (VARIANT_A)
					logicEnable <= 1'b1;
				if (state_r == TSS_UP && peakEvt && cycle_r == `TSS_CYC_GATE)
					protectionGateOut_n <= 1'b0;
				if (state_r == TSS_UP && peakEvt && cycle_r == `TSS_CYC_DELAY)
					delayedOutputGate_n <= 1'b0;
				if (stepUp && cycle_nxt == `TSS_CYC_BOOST)
				begin
					boostEnable <= 1'b1;
					logicEnable <= 1'b1;
				end
				if (stepUp && cycle_nxt == `TSS_CYC_ROWNEG)
					rowNegEnable <= 1'b1;
				if (stepUp && cycle_nxt == `TSS_CYC_ROWPOS)
					rowPosEnable <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	chk_off_quiet: assert property ((state_r == TSS_OFF) |-> !boostEnable && !rowNegEnable
		&& !rowPosEnable && protectionGateOut_n && delayedOutputGate_n && !delayCapCharge)
		else $error("Outputs active while powered down");
	chk_hold_disabled: assert property ((state_r == TSS_OFF && !sense_r.enable)
		|=> state_r == TSS_OFF && !delayCapCharge)
		else $error("Ramp started without enable");
	chk_six_peaks: assert property ((state_r == TSS_DOWN && state_nxt == TSS_DONE)
		|-> cycle_r == 3'h6)
		else $error("Sequence ended without six peaks");
	chk_fault_latch: assert property ((active && faultNow && runOk)
		|=> state_r == TSS_LATCH && faultLatched && protectionGateOut_n && !boostEnable)
		else $error("Fault did not latch off");
	chk_latch_hold: assert property ((state_r == TSS_LATCH && runOk) |=> state_r == TSS_LATCH)
		else $error("Latch released without enable or supply cycle");
	chk_gate_peak: assert property ($fell(protectionGateOut_n)
		|-> $past(cycle_r) == 3'h2 && $past(peakEvt) && state_r == TSS_DOWN)
		else $error("Protection gate not at second peak");
	chk_boost_start: assert property ($rose(boostEnable) |-> cycle_r == 3'h3 && state_r == TSS_UP)
		else $error("Boost started outside third ramp");
	chk_rowneg_on: assert property ($rose(rowNegEnable) |-> cycle_r == 3'h4 && state_r == TSS_UP)
		else $error("Negative row supply at wrong point");
	chk_delay_gate: assert property ($fell(delayedOutputGate_n) |-> cycle_r == 3'h5 && state_r == TSS_DOWN)
		else $error("Delayed gate at wrong point");
	chk_rowpos_on: assert property ($rose(rowPosEnable) |-> cycle_r == 3'h6 && state_r == TSS_UP)
		else $error("Positive row supply at wrong point");
	chk_overtemp_trip: assert property ((active && sense_r.overTemp)
		|=> !delayCapCharge && protectionGateOut_n && !rowPosEnable)
		else $error("Over-temperature did not shut down");
	chk_count_clear: assert property ((state_r == TSS_OFF) |-> cycle_r == 3'h0)
		else $error("Ramp count kept while powered down");

	cov_done: cover property (state_r == TSS_DOWN ##1 state_r == TSS_DONE);
	cov_init_fault: cover property ((cycle_r == 3'h1) && active && faultNow ##1 faultLatched);
	cov_release: cover property (state_r == TSS_LATCH ##1 state_r == TSS_OFF);
	cov_irq: cover property ($rose(irq));

endmodule // tss_sequencer

`default_nettype wire

// file: sim/tss_power_stage_model.sv
// Purpose: Delay capacitor and supply monitors seen by the sequencer
// Assumes: Each ramp takes RAMP cycles either way
// Notes: A monitor reports good only while its supply is switched on
`timescale 1ns/10ps
`default_nettype none

module tss_power_stage_model
#(
	parameter int RAMP = 12
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Drive from the sequencer
	input wire logic charge,
	input wire logic discharge,
	input wire logic boostOn,
	input wire logic rowNegOn,
	input wire logic rowPosOn,
	input wire logic logicOn,
	input wire logic gate_n,
	input wire logic delayGate_n,
	// Comparator levels
	output logic capHigh,
	output logic capLow,
	output logic boostDelayedOk,
	output logic protGateOk,
	output logic rowNegOk,
	output logic delayGateOk,
	output logic rowPosOk,
	output logic logicOk
);
	int level;

	////////////////////////////////////////
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			level <= 0;
		else if (charge && level < RAMP)
			level <= level + 1;
		else if (discharge && level > 0)
			level <= level - 1;
	end

	// Thresholds sit at the ends of the swing, so a stalled ramp never re-triggers
	assign capHigh = (level == RAMP);
	assign capLow = (level == 0);
	// Delayed output only exists once the pass switch is closed on a running boost
	assign boostDelayedOk = boostOn & ~delayGate_n;
	assign protGateOk = ~gate_n;
	assign rowNegOk = rowNegOn;
	assign delayGateOk = ~delayGate_n;
	assign rowPosOk = rowPosOn;
	assign logicOk = logicOn;
endmodule // tss_power_stage_model
`default_nettype wire

// file: sim/tss_sequencer_bench.sv
// Purpose: Self-checking bench of the start-up sequencer, base variant driving the stage model, second variant alongside
// Assumes: FAST_CYC shortened to 4, capacitor ramps of 12 cycles
// Notes: Faults are injected on the sense levels between register polls
`timescale 1ns/10ps
`default_nettype none
`include "tss_map.svh"

module tss_sequencer_bench;
	import tss_pkg::*;
	logic ref_clk, reset, en, sup, capFlt, refOk, oTemp, killPos;
	logic capHigh, capLow, bdOk, pgOk, rnOk, dgOk, rpOk, lgOk;
	logic dcCharge, delayCapFast, dcDis, refEnable, boostEnable, logicEnable;
	logic rowNegEnable, rowPosEnable, protectionGateOut_n, delayedOutputGate_n;
	logic faultLatched, irq;
	logic refEnableA, logicEnableA, faultLatchedA;
	logic [31:0] rdata, w;
	logic [7:0] outs;
	tss_bus_type bus;
	tss_sense_type sense;
	int badCount, compares, peaks, fastCnt, pkBoost, pkGate, pkNeg, pkDel, pkPos, pkLogA;

	assign sense = {en, sup, capHigh, capLow, capFlt, refOk, oTemp, bdOk, pgOk, rnOk, dgOk,
		rpOk & ~killPos, lgOk};
	assign outs = {refEnable, boostEnable, logicEnable, rowNegEnable, rowPosEnable,
		protectionGateOut_n, delayedOutputGate_n, dcCharge};

	tss_sequencer #(.VARIANT_A(1'b0), .FAST_CYC(4)) u_dut (.ref_clk(ref_clk), .reset(reset),
		.senseIn(sense), .busIn(bus), .rdata(rdata), .delayCapCharge(dcCharge),
		.delayCapFast(delayCapFast), .delayCapDischarge(dcDis), .refEnable(refEnable),
		.boostEnable(boostEnable), .logicEnable(logicEnable), .rowNegEnable(rowNegEnable),
		.rowPosEnable(rowPosEnable), .protectionGateOut_n(protectionGateOut_n),
		.delayedOutputGate_n(delayedOutputGate_n), .faultLatched(faultLatched), .irq(irq));

	// Second variant rides on the same sense levels, so it steps in lockstep with u_dut
	tss_sequencer #(.VARIANT_A(1'b1), .FAST_CYC(4)) u_dutA (.ref_clk(ref_clk), .reset(reset),
		.senseIn(sense), .busIn(bus), .rdata(), .delayCapCharge(), .delayCapFast(),
		.delayCapDischarge(), .refEnable(refEnableA), .boostEnable(),
		.logicEnable(logicEnableA), .rowNegEnable(), .rowPosEnable(),
		.protectionGateOut_n(), .delayedOutputGate_n(), .faultLatched(faultLatchedA),
		.irq());

	tss_power_stage_model #(.RAMP(12)) u_stage (.ref_clk(ref_clk), .reset(reset),
		.charge(dcCharge), .discharge(dcDis), .boostOn(boostEnable), .rowNegOn(rowNegEnable),
		.rowPosOn(rowPosEnable), .logicOn(logicEnable), .gate_n(protectionGateOut_n),
		.delayGate_n(delayedOutputGate_n), .capHigh(capHigh), .capLow(capLow),
		.boostDelayedOk(bdOk), .protGateOk(pgOk), .rowNegOk(rnOk), .delayGateOk(dgOk),
		.rowPosOk(rpOk), .logicOk(lgOk));

	////////////////////////////////////////
	always #5 ref_clk = ~ref_clk;
	// Peak count at which each output first moves, to check the order
	always @(posedge capHigh) peaks++;
	always @(posedge ref_clk) if (delayCapFast === 1'b1) fastCnt++;
	always @(posedge boostEnable) pkBoost = peaks;
	always @(negedge protectionGateOut_n) pkGate = peaks;
	always @(posedge rowNegEnable) pkNeg = peaks;
	always @(negedge delayedOutputGate_n) pkDel = peaks;
	always @(posedge rowPosEnable) pkPos = peaks;
	always @(posedge logicEnableA) pkLogA = peaks;

	////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus <= '{addr:a, wdata:d, wr:1'b1, rd:1'b0};
		@(posedge ref_clk);
		bus <= '0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		bus <= '{addr:a, wdata:32'h0, wr:1'b0, rd:1'b1};
		@(posedge ref_clk);
		bus <= '0;
		#1 d = rdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			badCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Polls the state field, bounded so a stuck sequencer cannot hang the run
	task automatic waitSt(input logic [2:0] s);
		logic [31:0] v;
		int n;
		n = 0;
		v = 32'hFFFF_FFFF;
		while (v[2:0] !== s && n < 400)
		begin
			rd(`TSS_ADDR_STATE, v);
			n++;
		end
		chk(v[2:0], s);
	endtask

	task automatic waitPk(input int k);
		int n;
		n = 0;
		while (peaks < k && n < 500)
		begin
			@(posedge ref_clk);
			n++;
		end
	endtask

	task automatic restart();
		en <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk(faultLatched, 1'b0);
		capFlt <= 1'b0;
		refOk <= 1'b1;
		killPos <= 1'b0;
		peaks = 0;
		en <= 1'b1;
	endtask

	task automatic results();
		$display("compares %0d mismatches %0d", compares, badCount);
		if (badCount == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////
	initial
	begin
		#200000;
		badCount++;
		results();
	end

	initial
	begin
		ref_clk = 1'b0;
		reset = 1'b1;
		bus = '0;
		en = 1'b0;
		sup = 1'b1;
		capFlt = 1'b0;
		refOk = 1'b1;
		oTemp = 1'b0;
		killPos = 1'b0;
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (40) @(posedge ref_clk);
		chk(outs, 8'h06);
		chk({refEnableA, logicEnableA}, 2'b10);
		waitSt(TSS_OFF);
		rd(`TSS_ADDR_CTRL, w);
		chk(w, 32'h1);
		rd(8'h10, w);
		chk(w, 32'h0);
		$display("done test idle");
		peaks = 0;
		fastCnt = 0;
		pkLogA = -1;
		en <= 1'b1;
		waitSt(TSS_DONE);
		chk(peaks, 6);
		chk(fastCnt, 24);
		chk(outs, 8'hF8);
		chk(pkGate, 2);
		chk(pkBoost, 2);
		chk(pkNeg, 3);
		chk(pkDel, 5);
		chk(pkPos, 5);
		chk(pkLogA, 0);
		chk({refEnableA, logicEnableA, faultLatchedA}, 3'b110);
		rd(`TSS_ADDR_STATE, w);
		chk(w[6:4], 3'h6);
		$display("done test power-up");
		chk(irq, 1'b0);
		wr(`TSS_ADDR_MASK, 32'h2);
		rd(`TSS_ADDR_STATUS, w);
		chk(w[1], 1'b1);
		chk(irq, 1'b1);
		wr(`TSS_ADDR_STATUS, 32'h2);
		rd(`TSS_ADDR_STATUS, w);
		chk(w[1], 1'b0);
		chk(irq, 1'b0);
		wr(`TSS_ADDR_MASK, 32'hF);
		$display("done test interrupt");
		oTemp <= 1'b1;
		waitSt(TSS_LATCH);
		chk(outs, 8'h06);
		chk({refEnableA, logicEnableA, faultLatchedA}, 3'b101);
		chk(irq, 1'b1);
		oTemp <= 1'b0;
		repeat (20) @(posedge ref_clk);
		chk(faultLatched, 1'b1);
		wr(`TSS_ADDR_STATUS, 32'hF);
		$display("done test over-temperature");
		restart();
		repeat (8) @(posedge ref_clk);
		capFlt <= 1'b1;
		waitSt(TSS_LATCH);
		chk(outs, 8'h06);
		chk(peaks, 0);
		$display("done test capacitor fault");
		restart();
		waitPk(1);
		refOk <= 1'b0;
		waitSt(TSS_LATCH);
		chk(protectionGateOut_n, 1'b1);
		$display("done test reference fault");
		restart();
		killPos <= 1'b1;
		waitSt(TSS_LATCH);
		chk(peaks, 6);
		chk(outs, 8'h06);
		$display("done test end check");
		results();
	end
endmodule // tss_sequencer_bench
`default_nettype wire
